//--- pkg/touch_status_pkg.sv
package touch_status_pkg;

    // Register addresses on the serial register port
    localparam logic [3:0] X_FIRST_ADDR = 4'h0;
    localparam logic [3:0] X_SECOND_ADDR = 4'h1;
    localparam logic [3:0] X_CURRENT_ADDR = 4'h2;
    localparam logic [3:0] Y_FIRST_ADDR = 4'h3;
    localparam logic [3:0] Y_SECOND_ADDR = 4'h4;
    localparam logic [3:0] Y_CURRENT_ADDR = 4'h5;
    localparam logic [3:0] PRESSURE_FIRST_ADDR = 4'h6;
    localparam logic [3:0] PRESSURE_SECOND_ADDR = 4'h7;
    localparam logic [3:0] DEVICE_STATUS_ADDR = 4'h8;
    localparam logic [3:0] SPARE_INPUT_ADDR = 4'h9;

    // Result slots, one per result register
    localparam int NUM_SLOTS = 9;
    localparam logic [3:0] SLOT_X_FIRST = 4'h0;
    localparam logic [3:0] SLOT_X_SECOND = 4'h1;
    localparam logic [3:0] SLOT_X_CURRENT = 4'h2;
    localparam logic [3:0] SLOT_Y_FIRST = 4'h3;
    localparam logic [3:0] SLOT_Y_SECOND = 4'h4;
    localparam logic [3:0] SLOT_Y_CURRENT = 4'h5;
    localparam logic [3:0] SLOT_PRESSURE_FIRST = 4'h6;
    localparam logic [3:0] SLOT_PRESSURE_SECOND = 4'h7;
    localparam logic [3:0] SLOT_SPARE_INPUT = 4'h8;

    // Data-ready flag index per data type (flag 4 sits in status bit 15)
    localparam int NUM_TYPES = 5;
    localparam logic [2:0] TYPE_X = 3'h4;
    localparam logic [2:0] TYPE_Y = 3'h3;
    localparam logic [2:0] TYPE_PRESSURE_FIRST = 3'h2;
    localparam logic [2:0] TYPE_PRESSURE_SECOND = 3'h1;
    localparam logic [2:0] TYPE_SPARE = 3'h0;

    // Status field positions
    localparam int STATUS_FLAGS_LSB = 11;
    localparam int STATUS_RESET_BIT = 7;
    localparam int STATUS_BIAS_POWER_DOWN_STATUS_BIT = 2;

    // Result word layout and reset values
    localparam int RESULT_BITS = 12;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic BIAS_STATUS_RESET = 1'h1;
    localparam logic RESET_SEEN_RESET = 1'h0;

    // Result write from the conversion sequencer
    typedef struct packed {
        logic valid;
        logic [3:0] slot;
        logic [11:0] data;
    } result_write_type;

endpackage

//--- src/result_word_reg.sv
`timescale 1ns/1ns
`default_nettype none
module result_word_reg #(
    parameter int WIDTH = 12
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clear_i,
    input wire logic wr_en_i,
    input wire logic ten_bit_i,
    input wire logic [WIDTH-1:0] data_i,
    // Stored word
    output logic [15:0] value_o
);

    logic [WIDTH-1:0] word_r;
    logic [WIDTH-1:0] word_nxt;

    // Two top result bits forced to zero in 10-bit mode
    always_comb
    begin
        word_nxt = data_i;
        if (ten_bit_i)
        begin
            word_nxt[WIDTH-1 -: 2] = 2'h0;
        end
    end

    // Word storage, cleared by either reset
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            word_r <= touch_status_pkg::RESULT_RESET[WIDTH-1:0];
        end
        else if (clear_i)
        begin
            word_r <= touch_status_pkg::RESULT_RESET[WIDTH-1:0];
        end
        else if (wr_en_i)
        begin
            word_r <= word_nxt;
        end
    end

    // Right-justified, upper bits zero
    assign value_o = {{(16 - WIDTH){1'b0}}, word_r};

    upper_zero_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        value_o[15:WIDTH] == '0)
        else $error("result upper bits not zero");
    ten_bit_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wr_en_i && ten_bit_i && !clear_i |=> value_o[WIDTH-1 -: 2] == 2'h0)
        else $error("10-bit result has upper bits set");
    store_value_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wr_en_i && !ten_bit_i && !clear_i |=> value_o[WIDTH-1:0] == $past(data_i))
        else $error("result word not stored");

endmodule // result_word_reg
`default_nettype wire

//--- src/touch_status_result_regs.sv
`timescale 1ns/1ns
`default_nettype none
module touch_status_result_regs #(
    parameter int RESULT_WIDTH = 12
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Register port from the serial engine
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Conversion sequencer
    input wire touch_status_pkg::result_write_type res_wr_i,
    input wire logic [4:0] store_done_i,
    input wire logic ten_bit_mode_i,
    input wire logic sw_reset_i,
    input wire logic conv_set_active_i,
    input wire logic sampling_i,
    input wire logic pen_touch_i,
    input wire logic conv_start_i,
    // Control byte bit
    input wire logic bias_power_down_select_i,
    // Status outputs
    output logic [4:0] data_ready_flags_o,
    output logic bias_power_down_o
);

    localparam int NS = touch_status_pkg::NUM_SLOTS;
    localparam int NT = touch_status_pkg::NUM_TYPES;

    logic [15:0] res_val [NS];
    logic [NS-1:0] slot_wr;
    logic [NS-1:0] slot_rd;
    logic [NS-1:0] pend_r;
    logic [NT-1:0] group_pend;
    logic [NT-1:0] flags_r;
    logic reset_seen_r;
    logic bias_power_down_status_r;
    logic bias_off_r;
    logic [15:0] status_word;
    logic status_rd;
    logic [15:0] rdata_r;
    logic rvalid_r;
    logic [15:0] rd_mux;

    // Register address of a result slot
    function automatic logic [3:0] slot_addr(input int slot);
        logic [3:0] a;
        unique case (slot)
            0: a = touch_status_pkg::X_FIRST_ADDR;
            1: a = touch_status_pkg::X_SECOND_ADDR;
            2: a = touch_status_pkg::X_CURRENT_ADDR;
            3: a = touch_status_pkg::Y_FIRST_ADDR;
            4: a = touch_status_pkg::Y_SECOND_ADDR;
            5: a = touch_status_pkg::Y_CURRENT_ADDR;
            6: a = touch_status_pkg::PRESSURE_FIRST_ADDR;
            7: a = touch_status_pkg::PRESSURE_SECOND_ADDR;
            default: a = touch_status_pkg::SPARE_INPUT_ADDR;
        endcase
        return a;
    endfunction

    // Data type that owns a result slot
    function automatic logic [2:0] slot_type(input int slot);
        logic [2:0] t;
        unique case (slot)
            0, 1, 2: t = touch_status_pkg::TYPE_X;
            3, 4, 5: t = touch_status_pkg::TYPE_Y;
            6: t = touch_status_pkg::TYPE_PRESSURE_FIRST;
            7: t = touch_status_pkg::TYPE_PRESSURE_SECOND;
            default: t = touch_status_pkg::TYPE_SPARE;
        endcase
        return t;
    endfunction

    // Status register read strobe
    assign status_rd = reg_rd_i && (reg_addr_i == touch_status_pkg::DEVICE_STATUS_ADDR);

    // One result register per slot
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++)
        begin : g_slot
            // Write goes only to the addressed slot
            assign slot_wr[gi] = res_wr_i.valid && (res_wr_i.slot == 4'(gi));
            assign slot_rd[gi] = reg_rd_i && (reg_addr_i == slot_addr(gi));
            result_word_reg #(
                .WIDTH(RESULT_WIDTH)
            ) u_word (
                .core_clk_i(core_clk_i),
                .rst_i(rst_i),
                .clear_i(sw_reset_i),
                .wr_en_i(slot_wr[gi]),
                .ten_bit_i(ten_bit_mode_i),
                .data_i(res_wr_i.data[RESULT_WIDTH-1:0]),
                .value_o(res_val[gi])
            );
        end
    endgenerate

    // Unread marks: set on update, cleared on host read, set wins
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pend_r <= '0;
        end
        else if (sw_reset_i)
        begin
            pend_r <= '0;
        end
        else
        begin
            pend_r <= slot_wr | (pend_r & ~slot_rd);
        end
    end

    // Outstanding unread registers per data type
    always_comb
    begin
        group_pend = '0;
        for (int s = 0; s < NS; s++)
        begin
            if (pend_r[s])
            begin
                group_pend[slot_type(s)] = 1'b1;
            end
        end
    end

    // Data-ready flags: set on store, hold until group read out
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            flags_r <= '0;
        end
        else if (sw_reset_i)
        begin
            flags_r <= '0;
        end
        else
        begin
            flags_r <= store_done_i | (flags_r & group_pend);
        end
    end

    // Reset-occurred flag: zero after reset, one after a status poll
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reset_seen_r <= touch_status_pkg::RESET_SEEN_RESET;
        end
        else if (sw_reset_i)
        begin
            reset_seen_r <= touch_status_pkg::RESET_SEEN_RESET;
        end
        else if (status_rd)
        begin
            reset_seen_r <= 1'b1;
        end
    end

    // Power-down status picks up the select bit on touch or start
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bias_power_down_status_r <= touch_status_pkg::BIAS_STATUS_RESET;
        end
        else if (sw_reset_i)
        begin
            bias_power_down_status_r <= touch_status_pkg::BIAS_STATUS_RESET;
        end
        else if (pen_touch_i || conv_start_i)
        begin
            bias_power_down_status_r <= bias_power_down_select_i;
        end
    end

    // Bias off between sets always, between samples when selected
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bias_off_r <= 1'b1;
        end
        else
        begin
            bias_off_r <= !conv_set_active_i || (bias_power_down_status_r && !sampling_i);
        end
    end

    // Status word with reserved bits at zero
    always_comb
    begin
        status_word = '0;
        status_word[touch_status_pkg::STATUS_FLAGS_LSB +: NT] = flags_r;
        status_word[touch_status_pkg::STATUS_RESET_BIT] = reset_seen_r;
        status_word[touch_status_pkg::STATUS_BIAS_POWER_DOWN_STATUS_BIT] = bias_power_down_status_r;
    end

    // Read data selection; unmapped addresses read zero
    always_comb
    begin
        rd_mux = '0;
        if (reg_addr_i == touch_status_pkg::DEVICE_STATUS_ADDR)
        begin
            rd_mux = status_word;
        end
        for (int s = 0; s < NS; s++)
        begin
            if (reg_addr_i == slot_addr(s))
            begin
                rd_mux = res_val[s];
            end
        end
    end

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= reg_rd_i;
            if (reg_rd_i)
            begin
                rdata_r <= rd_mux;
            end
        end
    end

    // Writes are accepted on the port but change nothing
    assign reg_rdata_o = rdata_r;
    assign reg_rvalid_o = rvalid_r;
    assign data_ready_flags_o = flags_r;
    assign bias_power_down_o = bias_off_r;

    dav_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (store_done_i != '0) && !sw_reset_i |=> (flags_r & $past(store_done_i)) == $past(store_done_i))
        else $error("data-ready flag not set on store");

    dav_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        flags_r[touch_status_pkg::TYPE_X] && group_pend[touch_status_pkg::TYPE_X] && !sw_reset_i
        |=> flags_r[touch_status_pkg::TYPE_X])
        else $error("X flag dropped before registers read");

    dav_drop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        flags_r[touch_status_pkg::TYPE_SPARE] && !pend_r[touch_status_pkg::SLOT_SPARE_INPUT]
        && !store_done_i[touch_status_pkg::TYPE_SPARE] |=> !flags_r[touch_status_pkg::TYPE_SPARE])
        else $error("spare flag stuck after read");

    cur_type_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        slot_wr[touch_status_pkg::SLOT_Y_CURRENT] && !sw_reset_i
        |=> group_pend[touch_status_pkg::TYPE_Y])
        else $error("Y current update not tied to Y flag");

    reset_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        status_rd && !sw_reset_i ##1 reg_rd_i && status_rd && !sw_reset_i
        |=> reg_rdata_o[touch_status_pkg::STATUS_RESET_BIT])
        else $error("reset flag still zero after poll");

    swreset_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sw_reset_i |=> !reset_seen_r)
        else $error("reset flag not cleared by software reset");

    bias_power_down_status_follow_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        conv_start_i && !sw_reset_i |=> bias_power_down_status_r == $past(bias_power_down_select_i))
        else $error("power-down status not loaded on start");

    bias_power_down_status_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !pen_touch_i && !conv_start_i && !sw_reset_i |=> $stable(bias_power_down_status_r))
        else $error("power-down status changed without touch or start");

    bias_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !conv_set_active_i |=> bias_power_down_o)
        else $error("bias on between conversion sets");

    clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sw_reset_i |=> res_val[touch_status_pkg::SLOT_X_FIRST] == touch_status_pkg::RESULT_RESET
        && flags_r == '0)
        else $error("software reset left state behind");

    status_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        status_rd |=> reg_rvalid_o && reg_rdata_o == $past(status_word))
        else $error("status read answered wrongly");

    reserved_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        status_rd |=> reg_rdata_o[10:8] == 3'h0 && reg_rdata_o[6:3] == 4'h0
        && reg_rdata_o[1:0] == 2'h0)
        else $error("reserved status bits not zero");

    write_ignored_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        reg_wr_i && !res_wr_i.valid && !sw_reset_i && store_done_i == '0 && !reg_rd_i
        |=> $stable(pend_r) && $stable(res_val[touch_status_pkg::SLOT_SPARE_INPUT]))
        else $error("register write had an effect");

    x_set_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
        store_done_i[touch_status_pkg::TYPE_X] ##[1:20] !flags_r[touch_status_pkg::TYPE_X]);
    poll_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
        status_rd ##1 reset_seen_r);
    bias_power_down_status_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
        bias_power_down_status_r ##1 !bias_power_down_status_r);
    ten_bit_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
        res_wr_i.valid && ten_bit_mode_i);

endmodule // touch_status_result_regs
`default_nettype wire

//--- test/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // Clock
    input wire logic core_clk_i,
    // Register port toward the device
    output logic [3:0] reg_addr_o,
    output logic reg_rd_o,
    output logic reg_wr_o,
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    // Idle port at time zero
    initial
    begin
        reg_addr_o = 4'h0;
        reg_rd_o = 1'b0;
        reg_wr_o = 1'b0;
    end

    // One read: strobe for one cycle, then wait a bounded time for the answer
    task automatic read_reg(input logic [3:0] addr, output logic [15:0] data, output logic ok);
        int i;
        begin
            ok = 1'b0;
            data = 16'hDEAD;
            @(posedge core_clk_i);
            #1;
            reg_addr_o = addr;
            reg_rd_o = 1'b1;
            @(posedge core_clk_i);
            #1;
            reg_rd_o = 1'b0;
            // Released address shows the inverse, not the old value
            reg_addr_o = ~addr;
            for (i = 0; i < 4; i++)
            begin
                if (reg_rvalid_i === 1'b1)
                begin
                    data = reg_rdata_i;
                    ok = 1'b1;
                    break;
                end
                @(posedge core_clk_i);
                #1;
            end
        end
    endtask

    // One write strobe; the bank must ignore it
    task automatic write_reg(input logic [3:0] addr);
        begin
            @(posedge core_clk_i);
            #1;
            reg_addr_o = addr;
            reg_wr_o = 1'b1;
            @(posedge core_clk_i);
            #1;
            reg_wr_o = 1'b0;
            reg_addr_o = ~addr;
        end
    endtask
endmodule // host_model
`default_nettype wire

//--- test/touch_status_result_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module touch_status_result_regs_tb;
    typedef struct packed {
        logic [3:0] slot;
        logic [11:0] data;
        logic ten;
        logic [15:0] exp;
    } row_type;
    logic core_clk_i, rst_i, reg_rd, reg_wr, reg_rvalid, ten_bit, sw_reset;
    logic conv_active, sampling, pen_touch, conv_start, pd_select, bias_pd;
    logic [3:0] reg_addr;
    logic [15:0] reg_rdata;
    logic [4:0] store_done, flags;
    touch_status_pkg::result_write_type res_wr;
    int n_errors = 0;
    int n_checks = 0;
    row_type rows [10] = '{
        '{4'h0, 12'hABC, 1'b0, 16'h0ABC}, '{4'h1, 12'h123, 1'b0, 16'h0123},
        '{4'h2, 12'hFFF, 1'b0, 16'h0FFF}, '{4'h3, 12'h456, 1'b0, 16'h0456},
        '{4'h4, 12'h800, 1'b0, 16'h0800}, '{4'h5, 12'h001, 1'b0, 16'h0001},
        '{4'h6, 12'h7E5, 1'b0, 16'h07E5}, '{4'h7, 12'h0F0, 1'b0, 16'h00F0},
        '{4'h8, 12'hFFF, 1'b0, 16'h0FFF}, '{4'h0, 12'hFFF, 1'b1, 16'h03FF}};

    // Device under test
    touch_status_result_regs dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr), .reg_rd_i(reg_rd), .reg_wr_i(reg_wr),
        .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .res_wr_i(res_wr),
        .store_done_i(store_done), .ten_bit_mode_i(ten_bit), .sw_reset_i(sw_reset),
        .conv_set_active_i(conv_active), .sampling_i(sampling), .pen_touch_i(pen_touch),
        .conv_start_i(conv_start), .bias_power_down_select_i(pd_select),
        .data_ready_flags_o(flags), .bias_power_down_o(bias_pd));

    // Host on the register port
    host_model host (.core_clk_i(core_clk_i), .reg_addr_o(reg_addr), .reg_rd_o(reg_rd),
        .reg_wr_o(reg_wr), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));

    // Clock
    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // Verdict and end of run
    task automatic summarize();
        begin
            $display("checks %0d errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    // Watchdog
    initial
    begin
        #100000;
        n_errors++;
        summarize();
    end

    // Data-ready flag index of a slot
    function automatic logic [2:0] type_of(input logic [3:0] s);
        if (s < 4'h3) return touch_status_pkg::TYPE_X;
        if (s < 4'h6) return touch_status_pkg::TYPE_Y;
        if (s == 4'h6) return touch_status_pkg::TYPE_PRESSURE_FIRST;
        if (s == 4'h7) return touch_status_pkg::TYPE_PRESSURE_SECOND;
        return touch_status_pkg::TYPE_SPARE;
    endfunction

    // Read a register and compare
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        begin
            host.read_reg(a, d, ok);
            `CHK("read answer", 1'b1, ok)
            `CHK("read data", exp, d)
        end
    endtask

    // One result word from the sequencer
    task automatic put(input logic [3:0] slot, input logic [11:0] data);
        begin
            @(posedge core_clk_i);
            #1;
            res_wr = '{valid: 1'b1, slot: slot, data: data};
            @(posedge core_clk_i);
            #1;
            res_wr.valid = 1'b0;
        end
    endtask

    // Set-stored pulse, one cycle
    task automatic done(input logic [2:0] ty);
        begin
            store_done[ty] = 1'b1;
            @(posedge core_clk_i);
            #1;
            store_done = 5'h00;
            @(posedge core_clk_i);
            #1;
        end
    endtask

    // Let a number of clock edges pass
    task automatic wait_cycles(input int n);
        begin
            repeat (n) @(posedge core_clk_i);
            #1;
        end
    endtask

    // Main sequence
    initial
    begin
        rst_i = 1'b1;
        ten_bit = 1'b0; sw_reset = 1'b0; conv_active = 1'b0; sampling = 1'b0;
        pen_touch = 1'b0; conv_start = 1'b0; pd_select = 1'b0;
        store_done = 5'h00;
        res_wr = '0;
        repeat (2) @(posedge core_clk_i);
        #1;
        rst_i = 1'b0;
        `CHK("flags after reset", 5'h00, flags)
        `CHK("bias after reset", 1'b1, bias_pd)
        rd(4'h8, 16'h0004);
        rd(4'h8, 16'h0084);
        rd(4'h0, 16'h0000);
        rd(4'hF, 16'h0000);
        host.write_reg(4'h8);
        host.write_reg(4'h0);
        rd(4'h8, 16'h0084);
        rd(4'h0, 16'h0000);
        // Ordinary cases: one word per slot, then a 10-bit word to slot 0; each stored, flagged, read, cleared
        foreach (rows[i])
        begin
            ten_bit = rows[i].ten;
            put(rows[i].slot, rows[i].data);
            ten_bit = 1'b0;
            done(type_of(rows[i].slot));
            `CHK("flag set", 1'b1, flags[type_of(rows[i].slot)])
            rd(rows[i].slot == 4'h8 ? 4'h9 : rows[i].slot, rows[i].exp);
            wait_cycles(2);
            `CHK("flag clear", 5'h00, flags)
        end
        // Full X set: flag holds until the last of three is read
        put(4'h0, 12'h111);
        put(4'h1, 12'h222);
        put(4'h2, 12'h333);
        done(touch_status_pkg::TYPE_X);
        rd(4'h8, 16'h8084);
        rd(4'h0, 16'h0111);
        rd(4'h1, 16'h0222);
        wait_cycles(2);
        `CHK("flag holds", 5'h10, flags)
        rd(4'h2, 16'h0333);
        wait_cycles(2);
        `CHK("flag after last", 5'h00, flags)
        // Single current word leaves the other X words alone
        put(4'h2, 12'h5A5);
        done(touch_status_pkg::TYPE_X);
        rd(4'h8, 16'h8084);
        rd(4'h0, 16'h0111);
        rd(4'h2, 16'h05A5);
        wait_cycles(2);
        `CHK("single flag clear", 5'h00, flags)
        // Power-down status loads only on touch or start
        pen_touch = 1'b1;
        wait_cycles(1);
        pen_touch = 1'b0;
        rd(4'h8, 16'h0080);
        pd_select = 1'b1;
        rd(4'h8, 16'h0080);
        conv_start = 1'b1;
        wait_cycles(1);
        conv_start = 1'b0;
        rd(4'h8, 16'h0084);
        // Bias power within and between conversion sets
        conv_active = 1'b1;
        wait_cycles(2);
        `CHK("bias between conversions", 1'b1, bias_pd)
        sampling = 1'b1;
        wait_cycles(2);
        `CHK("bias while sampling", 1'b0, bias_pd)
        conv_active = 1'b0;
        wait_cycles(2);
        `CHK("bias between sets", 1'b1, bias_pd)
        sampling = 1'b0;
        // Software reset clears results, flags and reset flag
        put(4'h8, 12'h777);
        done(touch_status_pkg::TYPE_SPARE);
        sw_reset = 1'b1;
        wait_cycles(1);
        sw_reset = 1'b0;
        wait_cycles(1);
        `CHK("flags after soft reset", 5'h00, flags)
        rd(4'h9, 16'h0000);
        rd(4'h8, 16'h0004);
        // Hardware reset in mid-run clears results and flags again
        put(4'h0, 12'h321);
        done(touch_status_pkg::TYPE_X);
        rst_i = 1'b1;
        wait_cycles(1);
        rst_i = 1'b0;
        `CHK("flags after hard reset", 5'h00, flags)
        rd(4'h0, 16'h0000);
        rd(4'h8, 16'h0004);
        summarize();
    end
endmodule // touch_status_result_regs_tb
`undef CHK
`default_nettype wire
